//--- emif_async_defs.svh
// Constants for the asynchronous memory strobe engine
// How it works
// RQ1 - Ready ignored until two cycles before end
// RQ2 - Ready low extends strobe one cycle each
// RQ3 - Strobe ends two cycles after ready high
// RQ4 - Ready input synchronised, hold two periods
// RQ5 - Port clock from pin, CPU/4 or CPU/6
// RQ6 - Divided clock output: port clock / 1,2,4
// RQ7 - Divided clock half duty, rising-edge launched
// RQ8 - Primary clock output follows port clock
// RQ9 - Read selects valid setup periods before strobe
// RQ10 - Read selects held hold periods after strobe
// RQ11 - Write selects, data valid setup periods before
// RQ12 - Write selects, data held hold periods after
// RQ13 - Timing counts from accessed space's register
// RQ14 - Selects: chip select, bytes, address, enable
// RQ15 - Strobes change only on primary rising edges
// RQ16 - Read data captured at read strobe rise
// RQ17 - Software programs read strobe long enough
// RQ18 - Strobes active low, never both asserted
`ifndef EMIF_ASYNC_DEFS_SVH
`define EMIF_ASYNC_DEFS_SVH
// ======================================
// Register byte offsets
`define OFS_CLK_CTRL 8'h00
`define OFS_ADDR     8'h04
`define OFS_WDATA_LO 8'h08
`define OFS_WDATA_HI 8'h0C
`define OFS_CMD      8'h10
`define OFS_STATUS   8'h14
`define OFS_RDATA_LO 8'h18
`define OFS_RDATA_HI 8'h1C
`define OFS_CE_BASE  8'h20
`define OFS_CE_MASK  8'hF0
// ======================================
// Fields and reset values
`define CMD_WR_BIT   0
`define CMD_CS_LSB   1
`define CMD_BE_LSB   8
`define CLK_SRC_LSB  0
`define CLK_DIV_LSB  2
`define CLK_CTRL_RST 4'h1
`define CE_CFG_W     26
`define CE_RST       26'h1104882
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
// ======================================
// Timing counts
`define CPU4_DIV     3'h4
`define CPU6_DIV     3'h6
`define RDY_WINDOW   6'h2
`define RDY_TAIL     6'h2
`endif

//--- emif_async_pkg.sv
// Types for the asynchronous memory strobe engine
package emif_async_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_LOAD   = 3'h1,
		ST_SETUP  = 3'h3,
		ST_STROBE = 3'h2,
		ST_HOLD   = 3'h6
	} eng_state_type;
	typedef enum logic [1:0] {SRC_EXT = 2'h0, SRC_CPU4 = 2'h1, SRC_CPU6 = 2'h2} clk_src_type;
	typedef enum logic [1:0] {DIV_1 = 2'h0, DIV_2 = 2'h1, DIV_4 = 2'h2} clk_div_type;
	typedef struct packed {
		logic [2:0] w_hold;
		logic [5:0] w_strobe;
		logic [3:0] w_setup;
		logic [2:0] r_hold;
		logic [5:0] r_strobe;
		logic [3:0] r_setup;
	} ce_cfg_type;
	typedef struct packed {
		logic        write;
		logic [1:0]  cs;
		logic [7:0]  be;
		logic [19:0] addr;
	} access_type;
endpackage

//--- cfg_memory.sv
// Chip-enable space timing store with registered read ports
`timescale 1ns/1ps
module cfg_memory #(
	parameter int               DEPTH   = 4,
	parameter int               WIDTH   = 26,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
	output logic      [WIDTH-1:0]         rdata_a,
	input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
	output logic      [WIDTH-1:0]         rdata_b
);
	generate
		if (DEPTH < 2 || WIDTH < 1) begin : g_bad
			$error("DEPTH must be at least 2 and WIDTH at least 1");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] rda_next;
	logic [WIDTH-1:0] rdb_next;

	always_comb begin
		rda_next = mem_reg[raddr_a];
		rdb_next = mem_reg[raddr_b];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= RST_VAL;
			end
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			if (we) begin
				mem_reg[waddr] <= wdata;
			end
			rdata_a <= rda_next;
			rdata_b <= rdb_next;
		end
	end
endmodule // cfg_memory

//--- port_clock_gen.sv
// Port input clock selection and memory clock outputs
`timescale 1ns/1ps
`include "emif_async_defs.svh"
module port_clock_gen (
	input  wire logic                      clk,
	input  wire logic                      arst_n,
	input  wire emif_async_pkg::clk_src_type src,
	input  wire emif_async_pkg::clk_div_type div,
	input  wire logic                      ext_clk,
	output logic                           pclk_rise,
	output logic                           clk_primary,
	output logic                           clk_divided
);
	import emif_async_pkg::*;
	logic       ext_s1_reg, ext_s2_reg;
	logic [2:0] cnt_reg, cnt_next;
	logic       prim_next, div_next;
	logic       phase_reg, phase_next;
	logic [2:0] lim;

	// ======================================
	// Source select and divider
	always_comb begin
		lim = (src == SRC_CPU6) ? `CPU6_DIV : `CPU4_DIV;
		cnt_next = (src == SRC_EXT) ? 3'h7 : (cnt_reg >= lim - 3'h1) ? 3'h0 : cnt_reg + 3'h1;
		if (src == SRC_EXT) begin // RQ5
			prim_next = ext_s2_reg; // RQ8
		end else begin
			prim_next = cnt_next < (lim >> 1); // RQ5
		end
		pclk_rise = prim_next && !clk_primary;
		phase_next = pclk_rise ? !phase_reg : phase_reg;
		case (div) // RQ6 RQ7
			DIV_2:   div_next = pclk_rise ? !clk_divided : clk_divided;
			DIV_4:   div_next = (pclk_rise && phase_reg) ? !clk_divided : clk_divided;
			default: div_next = prim_next;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_s1_reg  <= 1'b0;
			ext_s2_reg  <= 1'b0;
			cnt_reg     <= 3'h7;
			clk_primary <= 1'b0;
			clk_divided <= 1'b0;
			phase_reg   <= 1'b0;
		end else begin
			ext_s1_reg  <= ext_clk;
			ext_s2_reg  <= ext_s1_reg;
			cnt_reg     <= cnt_next;
			clk_primary <= prim_next;
			clk_divided <= div_next;
			phase_reg   <= phase_next;
		end
	end

	// ======================================
	// Checks
	a_div_launch: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
		(div != DIV_1 && $stable(div) && $changed(clk_divided)) |-> $past(pclk_rise))
		else $error("divided clock moved without a port clock rise");
	a_cpu4_period: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
		(src == SRC_CPU4 && $stable(src) && $rose(clk_primary)) |-> ##1 clk_primary ##1 !clk_primary ##1 !clk_primary)
		else $error("CPU/4 port clock not two high two low");
	a_ext_follow: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
		(src == SRC_EXT && $stable(src)) |-> clk_primary == $past(ext_clk, 3))
		else $error("primary clock does not follow the pin");
endmodule // port_clock_gen

//--- emif_async_port.sv
// Asynchronous memory strobe engine with AXI4-Lite registers
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "emif_async_defs.svh"
module emif_async_port #(
	parameter int DATA_W = 64,
	parameter int NUM_CE = 4
) (
	input  wire logic                CLK_SYS,
	input  wire logic                ARST_N,
	input  wire logic [7:0]          S_AXI_AWADDR,
	input  wire logic                S_AXI_AWVALID,
	output logic                     S_AXI_AWREADY,
	input  wire logic [31:0]         S_AXI_WDATA,
	input  wire logic [3:0]          S_AXI_WSTRB,
	input  wire logic                S_AXI_WVALID,
	output logic                     S_AXI_WREADY,
	output logic [1:0]               S_AXI_BRESP,
	output logic                     S_AXI_BVALID,
	input  wire logic                S_AXI_BREADY,
	input  wire logic [7:0]          S_AXI_ARADDR,
	input  wire logic                S_AXI_ARVALID,
	output logic                     S_AXI_ARREADY,
	output logic [31:0]              S_AXI_RDATA,
	output logic [1:0]               S_AXI_RRESP,
	output logic                     S_AXI_RVALID,
	input  wire logic                S_AXI_RREADY,
	input  wire logic                PORT_EXT_CLOCK_IN,
	input  wire logic                READY_WAIT_INPUT,
	output logic                     EMIF_CLOCK_OUT_PRIMARY,
	output logic                     EMIF_CLOCK_OUT_DIVIDED,
	output logic [NUM_CE-1:0]        CHIP_SELECT_N,
	output logic [DATA_W/8-1:0]      BYTE_ENABLE_N,
	output logic [19:0]              EXTERNAL_ADDRESS,
	output logic                     OUTPUT_ENABLE_N,
	output logic                     READ_STROBE_N,
	output logic                     WRITE_STROBE_N,
	output logic [DATA_W-1:0]        EXTERNAL_DATA_BUS_OUT,
	output logic                     EXTERNAL_DATA_BUS_OE,
	input  wire logic [DATA_W-1:0]   READ_DATA_BUS_IN
);
	import emif_async_pkg::*;
	localparam int BE_W = DATA_W / 8;

	generate
		if (!(DATA_W == 64 || DATA_W == 16) || NUM_CE < 1 || NUM_CE > 4) begin : g_bad
			$error("DATA_W must be 16 or 64 and NUM_CE 1 to 4");
		end
	endgenerate

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	function automatic logic [5:0] at_least_one(input logic [5:0] v);
		return (v == 6'h0) ? 6'h1 : v;
	endfunction

	// ======================================
	// Declarations
	logic              rdy_s1_reg, rdy_s2_reg;
	logic [DATA_W-1:0] rdin_s1_reg, rdin_s2_reg;
	logic              aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [7:0]        awaddr_reg, awaddr_next, araddr_reg, araddr_next;
	logic [31:0]       wdat_reg, wdat_next, rdat_reg, rdat_next;
	logic [3:0]        wstrb_reg, wstrb_next;
	logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, rpend_reg, rpend_next;
	logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [3:0]        clk_ctrl_reg, clk_ctrl_next;
	logic [19:0]       addr_reg, addr_next;
	logic [63:0]       wdata_reg, wdata_next, wbuf_reg, wbuf_next, rdata_reg, rdata_next;
	logic              done_reg, done_next, seen_low_reg, seen_low_next;
	logic              rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
	eng_state_type     state_reg, state_next;
	access_type        acc_reg, acc_next;
	ce_cfg_type        cfg_reg, cfg_next, ram_cfg_a;
	logic [5:0]        cnt_reg, cnt_next;
	logic [NUM_CE-1:0] cs_n_next;
	logic [BE_W-1:0]   be_n_next;
	logic              oe_n_next, dout_oe_next, sel_next;
	logic              do_write, do_cmd, full, wr_ok, ce_w, ce_r, pclk_rise;
	logic [7:0]        wa;
	logic [`CE_CFG_W-1:0] ram_rdata_a, ram_rdata_b;
	logic [1:0]        ram_raddr_a;

	// ======================================
	// Input synchronisers
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rdy_s1_reg  <= 1'b1;
			rdy_s2_reg  <= 1'b1;
			rdin_s1_reg <= '0;
			rdin_s2_reg <= '0;
		end else begin
			rdy_s1_reg  <= READY_WAIT_INPUT; // RQ4
			rdy_s2_reg  <= rdy_s1_reg;
			rdin_s1_reg <= READ_DATA_BUS_IN;
			rdin_s2_reg <= rdin_s1_reg;
		end
	end

	// ======================================
	// Clocking and timing store
	port_clock_gen u_clk (
		.clk         (CLK_SYS),
		.arst_n      (ARST_N),
		.src         (clk_src_type'(clk_ctrl_reg[`CLK_SRC_LSB +: 2])),
		.div         (clk_div_type'(clk_ctrl_reg[`CLK_DIV_LSB +: 2])),
		.ext_clk     (PORT_EXT_CLOCK_IN),
		.pclk_rise   (pclk_rise),
		.clk_primary (EMIF_CLOCK_OUT_PRIMARY),
		.clk_divided (EMIF_CLOCK_OUT_DIVIDED)
	);

	assign ram_raddr_a = do_cmd ? wdat_reg[`CMD_CS_LSB +: 2] : acc_reg.cs; // RQ13
	assign ram_cfg_a   = ce_cfg_type'(ram_rdata_a);

	cfg_memory #(.DEPTH(4), .WIDTH(`CE_CFG_W), .RST_VAL(`CE_RST)) u_cfg (
		.clk     (CLK_SYS),
		.arst_n  (ARST_N),
		.we      (do_write && full && ce_w),
		.waddr   (wa[3:2]),
		.wdata   (wdat_reg[`CE_CFG_W-1:0]),
		.raddr_a (ram_raddr_a),
		.rdata_a (ram_rdata_a),
		.raddr_b (S_AXI_ARADDR[3:2]),
		.rdata_b (ram_rdata_b)
	);

	// ======================================
	// AXI4-Lite slave
	assign wa            = {awaddr_reg[7:2], 2'h0};
	assign full          = wstrb_reg == 4'hF;
	assign ce_w          = (wa & `OFS_CE_MASK) == `OFS_CE_BASE && {1'b0, wa[3:2]} < 3'(NUM_CE);
	assign ce_r          = (araddr_reg & `OFS_CE_MASK) == `OFS_CE_BASE && {1'b0, araddr_reg[3:2]} < 3'(NUM_CE);
	assign do_write      = aw_have_reg && w_have_reg && !bvalid_reg;
	assign do_cmd        = do_write && full && wa == `OFS_CMD && state_reg == ST_IDLE;
	assign wr_ok         = full && (wa == `OFS_CLK_CTRL || wa == `OFS_ADDR || wa == `OFS_WDATA_LO
	                       || wa == `OFS_WDATA_HI || ce_w || do_cmd);
	assign S_AXI_AWREADY = !aw_have_reg && !bvalid_reg;
	assign S_AXI_WREADY  = !w_have_reg && !bvalid_reg;
	assign S_AXI_ARREADY = !rpend_reg && !rvalid_reg;
	assign S_AXI_BVALID  = bvalid_reg;
	assign S_AXI_BRESP   = bresp_reg;
	assign S_AXI_RVALID  = rvalid_reg;
	assign S_AXI_RRESP   = rresp_reg;
	assign S_AXI_RDATA   = rdat_reg;

	always_comb begin
		aw_have_next  = aw_have_reg;
		w_have_next   = w_have_reg;
		awaddr_next   = awaddr_reg;
		wdat_next     = wdat_reg;
		wstrb_next    = wstrb_reg;
		bvalid_next   = bvalid_reg;
		bresp_next    = bresp_reg;
		araddr_next   = araddr_reg;
		rpend_next    = rpend_reg;
		rvalid_next   = rvalid_reg;
		rresp_next    = rresp_reg;
		rdat_next     = rdat_reg;
		clk_ctrl_next = clk_ctrl_reg;
		addr_next     = addr_reg;
		wdata_next    = wdata_reg;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_have_next = 1'b1;
			awaddr_next  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_have_next = 1'b1;
			wdat_next   = S_AXI_WDATA;
			wstrb_next  = S_AXI_WSTRB;
		end
		if (bvalid_reg && S_AXI_BREADY) begin
			bvalid_next = 1'b0;
		end
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			if (full) begin
				case (wa)
					`OFS_CLK_CTRL: clk_ctrl_next = wdat_reg[3:0]; // RQ5 RQ6
					`OFS_ADDR:     addr_next = wdat_reg[19:0];
					`OFS_WDATA_LO: wdata_next[31:0] = wdat_reg;
					`OFS_WDATA_HI: wdata_next[63:32] = wdat_reg;
					default: ;
				endcase
			end
		end
		if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_next = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rpend_next  = 1'b1;
			araddr_next = {S_AXI_ARADDR[7:2], 2'h0};
		end
		if (rpend_reg) begin
			rpend_next  = 1'b0;
			rvalid_next = 1'b1;
			rresp_next  = `RESP_OKAY;
			case (araddr_reg)
				`OFS_CLK_CTRL: rdat_next = {28'h0, clk_ctrl_reg};
				`OFS_ADDR:     rdat_next = {12'h0, addr_reg};
				`OFS_WDATA_LO: rdat_next = wdata_reg[31:0];
				`OFS_WDATA_HI: rdat_next = wdata_reg[63:32];
				`OFS_CMD:      rdat_next = {16'h0, acc_reg.be, 5'h0, acc_reg.cs, acc_reg.write};
				`OFS_STATUS:   rdat_next = {30'h0, done_reg, state_reg != ST_IDLE};
				`OFS_RDATA_LO: rdat_next = rdata_reg[31:0];
				`OFS_RDATA_HI: rdat_next = rdata_reg[63:32];
				default: begin
					rdat_next  = ce_r ? {6'h0, ram_rdata_b} : 32'h0;
					rresp_next = ce_r ? `RESP_OKAY : `RESP_SLVERR;
				end
			endcase
		end
	end

	// ======================================
	// Strobe engine
	always_comb begin
		state_next    = state_reg;
		acc_next      = acc_reg;
		cfg_next      = cfg_reg;
		cnt_next      = cnt_reg;
		seen_low_next = seen_low_reg;
		rd_n_next     = rd_n_reg;
		wr_n_next     = wr_n_reg;
		done_next     = done_reg;
		rdata_next    = rdata_reg;
		wbuf_next     = wbuf_reg;
		case (state_reg)
			ST_IDLE: begin
				if (do_cmd) begin
					acc_next.write = wdat_reg[`CMD_WR_BIT];
					acc_next.cs    = wdat_reg[`CMD_CS_LSB +: 2];
					acc_next.be    = wdat_reg[`CMD_BE_LSB +: 8];
					acc_next.addr  = addr_reg;
					wbuf_next      = wdata_reg;
					done_next      = 1'b0;
					state_next     = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (pclk_rise) begin
					cfg_next   = ram_cfg_a; // RQ13
					cnt_next   = at_least_one(6'(acc_reg.write ? ram_cfg_a.w_setup : ram_cfg_a.r_setup));
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (pclk_rise) begin
					if (cnt_reg == 6'h1) begin // RQ9 RQ11
						cnt_next      = at_least_one(acc_reg.write ? cfg_reg.w_strobe : cfg_reg.r_strobe);
						rd_n_next     = acc_reg.write; // RQ15 RQ18
						wr_n_next     = !acc_reg.write;
						seen_low_next = 1'b0;
						state_next    = ST_STROBE;
					end else begin
						cnt_next = cnt_reg - 6'h1;
					end
				end
			end
			ST_STROBE: begin
				if (pclk_rise) begin
					if (cnt_reg > `RDY_WINDOW) begin
						cnt_next = cnt_reg - 6'h1; // RQ1
					end else if (!rdy_s2_reg) begin
						seen_low_next = 1'b1; // RQ2
					end else if (seen_low_reg) begin
						seen_low_next = 1'b0; // RQ3
						cnt_next      = `RDY_TAIL;
					end else if (cnt_reg == 6'h1) begin
						rd_n_next  = 1'b1; // RQ15
						wr_n_next  = 1'b1;
						cnt_next   = at_least_one(6'(acc_reg.write ? cfg_reg.w_hold : cfg_reg.r_hold));
						state_next = ST_HOLD;
						if (!acc_reg.write) begin
							rdata_next = 64'(rdin_s2_reg); // RQ16
						end
					end else begin
						cnt_next = cnt_reg - 6'h1;
					end
				end
			end
			ST_HOLD: begin
				if (pclk_rise) begin
					if (cnt_reg == 6'h1) begin // RQ10 RQ12
						state_next = ST_IDLE;
						done_next  = 1'b1;
					end else begin
						cnt_next = cnt_reg - 6'h1;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// ======================================
	// Select outputs
	always_comb begin
		sel_next     = state_next == ST_SETUP || state_next == ST_STROBE || state_next == ST_HOLD;
		be_n_next    = sel_next ? ~acc_next.be[BE_W-1:0] : '1; // RQ14
		oe_n_next    = !(sel_next && !acc_next.write);
		dout_oe_next = sel_next && acc_next.write; // RQ11 RQ12
	end

	generate
		for (genvar i = 0; i < NUM_CE; i++) begin : g_cs
			assign cs_n_next[i] = !(sel_next && acc_next.cs == 2'(i)); // RQ14
		end
	endgenerate

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdat_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			araddr_reg <= 8'h00;
			rpend_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= `RESP_OKAY;
			rdat_reg <= 32'h0;
			clk_ctrl_reg <= `CLK_CTRL_RST;
			addr_reg <= 20'h0;
			wdata_reg <= 64'h0;
			state_reg <= ST_IDLE;
			acc_reg <= '0;
			cfg_reg <= '0;
			cnt_reg <= 6'h0;
			seen_low_reg <= 1'b0;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			done_reg <= 1'b0;
			rdata_reg <= 64'h0;
			wbuf_reg <= 64'h0;
			CHIP_SELECT_N <= '1;
			BYTE_ENABLE_N <= '1;
			OUTPUT_ENABLE_N <= 1'b1;
			EXTERNAL_DATA_BUS_OE <= 1'b0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdat_reg <= wdat_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			araddr_reg <= araddr_next;
			rpend_reg <= rpend_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdat_reg <= rdat_next;
			clk_ctrl_reg <= clk_ctrl_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			state_reg <= state_next;
			acc_reg <= acc_next;
			cfg_reg <= cfg_next;
			cnt_reg <= cnt_next;
			seen_low_reg <= seen_low_next;
			rd_n_reg <= rd_n_next;
			wr_n_reg <= wr_n_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
			wbuf_reg <= wbuf_next;
			CHIP_SELECT_N <= cs_n_next;
			BYTE_ENABLE_N <= be_n_next;
			OUTPUT_ENABLE_N <= oe_n_next;
			EXTERNAL_DATA_BUS_OE <= dout_oe_next;
		end
	end

	assign READ_STROBE_N         = rd_n_reg;
	assign WRITE_STROBE_N        = wr_n_reg;
	assign EXTERNAL_ADDRESS      = acc_reg.addr;
	assign EXTERNAL_DATA_BUS_OUT = wbuf_reg[DATA_W-1:0];

	// ======================================
	// Checks
	a_strobe_exclusive: assert property (!(!rd_n_reg && !wr_n_reg)) // RQ18
		else $error("read and write strobes both low");
	a_strobe_on_tick: assert property (($changed(rd_n_reg) || $changed(wr_n_reg)) |-> $past(pclk_rise)) // RQ15
		else $error("strobe moved without a primary clock rise");
	a_setup_to_strobe: assert property ((state_reg == ST_SETUP && pclk_rise && cnt_reg == 6'h1) // RQ9 RQ11
		|=> (rd_n_reg != wr_n_reg) && CHIP_SELECT_N != '1 && $past(CHIP_SELECT_N) == CHIP_SELECT_N)
		else $error("strobe asserted without selects set up");
	a_hold_after: assert property (($rose(rd_n_reg) || $rose(wr_n_reg)) // RQ10 RQ12
		|-> state_reg == ST_HOLD && CHIP_SELECT_N != '1 && $stable(EXTERNAL_ADDRESS))
		else $error("selects dropped with the strobe");
	a_ready_early: assert property ((state_reg == ST_STROBE && pclk_rise && cnt_reg > 6'h2) // RQ1
		|=> cnt_reg == $past(cnt_reg) - 6'h1)
		else $error("ready acted outside its window");
	a_ready_extend: assert property ((state_reg == ST_STROBE && pclk_rise && cnt_reg <= 6'h2 && !rdy_s2_reg) // RQ2
		|=> state_reg == ST_STROBE && cnt_reg == $past(cnt_reg))
		else $error("strobe not held while ready low");
	a_ready_tail: assert property ((state_reg == ST_STROBE && pclk_rise && cnt_reg <= 6'h2 && rdy_s2_reg // RQ3
		&& seen_low_reg) |=> cnt_reg == 6'h2 && !seen_low_reg)
		else $error("strobe tail after ready high is not two cycles");
	a_read_capture: assert property ($rose(rd_n_reg) |-> rdata_reg == 64'($past(rdin_s2_reg))) // RQ16
		else $error("read data not captured at strobe rise");
	a_lane_select: assert property ((state_reg == ST_STROBE) // RQ14
		|-> BYTE_ENABLE_N == ~acc_reg.be[BE_W-1:0] && OUTPUT_ENABLE_N == acc_reg.write)
		else $error("byte enables or output enable wrong in strobe");
	a_cfg_source: assert property ((state_reg == ST_LOAD && pclk_rise) |=> cfg_reg == $past(ram_cfg_a)) // RQ13
		else $error("timing not taken from the accessed space");
	a_rdy_sync: assert property (rdy_s2_reg == $past(READY_WAIT_INPUT, 2) || $past(!ARST_N, 2)) // RQ4
		else $error("ready input not passed through two flip-flops");
	c_read_done: cover property ($rose(rd_n_reg) ##[1:200] (state_reg == ST_IDLE && done_reg));
	c_write_done: cover property ($rose(wr_n_reg) ##[1:200] (state_reg == ST_IDLE && done_reg));
	c_ready_stretch: cover property (state_reg == ST_STROBE && pclk_rise && !rdy_s2_reg && cnt_reg <= 6'h2);
endmodule // emif_async_port

//--- mem_model.sv
// Behavioural asynchronous memory facing the port
`timescale 1ns/1ps
module mem_model (
	input  wire logic        tick,
	input  wire logic        sel_n,
	input  wire logic        oe_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [3:0]  addr,
	input  wire logic [63:0] wdata,
	input  wire logic [7:0]  wf,
	input  wire logic [7:0]  wt,
	output logic             rdy,
	output logic [63:0]      rdata
);
	logic [63:0] mem [16];
	int          k = 0;
	initial rdy = 1'b1;
	initial rdata = '0;
	initial foreach (mem[i]) mem[i] = {16{4'(i)}};
	// ======================================
	// Wait request in whole ticks of the strobe
	always @(posedge tick) begin
		#1;
		k = (!rd_n || !wr_n) ? k + 1 : 0;
		rdy = !(k >= wf && k < wt);
	end
	always @(posedge wr_n) if (!sel_n) mem[addr] = wdata;
	// Data while enabled, scrambled when released
	always @(sel_n, oe_n, addr) rdata = (!sel_n && !oe_n) ? mem[addr] : ~rdata;
endmodule // mem_model

//--- test_async_memory_strobe_clocking.sv
// Testbench for the asynchronous memory strobe engine
`timescale 1ns/1ps
`include "emif_async_defs.svh"
module test_async_memory_strobe_clocking;
	import emif_async_pkg::*;
	logic CLK_SYS = 0, ARST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
	logic S_AXI_RREADY = 0, PORT_EXT_CLOCK_IN = 0, READY_WAIT_INPUT, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, EMIF_CLOCK_OUT_PRIMARY, EMIF_CLOCK_OUT_DIVIDED, OUTPUT_ENABLE_N;
	logic READ_STROBE_N, WRITE_STROBE_N, EXTERNAL_DATA_BUS_OE, pick = 0, strobed;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	logic [3:0]  S_AXI_WSTRB = 4'hF, CHIP_SELECT_N, cs_seen;
	logic [7:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, BYTE_ENABLE_N, wf = 0, wt = 0;
	logic [19:0] EXTERNAL_ADDRESS;
	logic [9:0]  lane_seen;
	logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, v;
	logic [63:0] EXTERNAL_DATA_BUS_OUT, READ_DATA_BUS_IN;
	int          bad_count = 0, samples_checked = 0, su, st, ho, ec = 0;
	wire         sel_clk = pick ? EMIF_CLOCK_OUT_DIVIDED : EMIF_CLOCK_OUT_PRIMARY;
	emif_async_port uut (.*);
	mem_model mem (.tick(EMIF_CLOCK_OUT_PRIMARY), .sel_n(&CHIP_SELECT_N), .oe_n(OUTPUT_ENABLE_N),
		.rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N), .addr(EXTERNAL_ADDRESS[3:0]),
		.wdata(EXTERNAL_DATA_BUS_OUT), .wf(wf), .wt(wt), .rdy(READY_WAIT_INPUT), .rdata(READ_DATA_BUS_IN));
	always #5 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) begin
		ec <= (ec == 4) ? 0 : ec + 1;
		if (ec == 4) PORT_EXT_CLOCK_IN <= !PORT_EXT_CLOCK_IN;
	end
	// ======================================
	// Phase counter per memory clock tick
	always @(posedge EMIF_CLOCK_OUT_PRIMARY) begin
		#1;
		if (!READ_STROBE_N || !WRITE_STROBE_N) begin
			st++;
			strobed = 1;
			cs_seen = CHIP_SELECT_N;
			lane_seen = {EXTERNAL_DATA_BUS_OE, OUTPUT_ENABLE_N, BYTE_ENABLE_N};
		end else if (!(&CHIP_SELECT_N)) begin
			if (strobed) ho++;
			else su++;
		end
	end
	task chk(input logic [63:0] s, input logic [63:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'b0;
		chk(S_AXI_BRESP, er);
		@(posedge CLK_SYS);
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(posedge CLK_SYS); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge CLK_SYS); while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'b0;
		d = S_AXI_RDATA;
		chk(S_AXI_RRESP, er);
		@(posedge CLK_SYS);
	endtask
	task pw(input logic d, input int e);
		int n [2];
		pick = d;
		n = '{0, 0};
		@(posedge CLK_SYS);
		@(posedge sel_clk);
		for (int i = 0; i < 2; i++) while (sel_clk == !i) begin
			@(posedge CLK_SYS);
			#1;
			n[i]++;
		end
		chk(n[0], e);
		chk(n[1], e);
	endtask
	task acc(input logic w, input logic [1:0] c, input ce_cfg_type g, input logic [7:0] f, t, input int et);
		logic [31:0] s;
		wr(`OFS_CE_BASE + {4'h0, c, 2'h0}, 32'(g), 2'h0);
		wr(`OFS_ADDR, 32'(c), 2'h0);
		su = 0;
		st = 0;
		ho = 0;
		strobed = 0;
		wf = f;
		wt = t;
		wr(`OFS_CMD, {16'h0, 8'hFF, 5'h0, c, w}, 2'h0);
		wr(`OFS_CMD, 32'h1, 2'h2);
		s = 0;
		while (!s[1]) rd(`OFS_STATUS, 2'h0, s);
		chk(su, w ? g.w_setup : g.r_setup);
		chk(st, et);
		chk(ho, w ? g.w_hold : g.r_hold);
		chk(cs_seen, 4'(~(4'h1 << c)));
		chk(lane_seen, {w, w, 8'h00});
		chk(EXTERNAL_ADDRESS, 20'(c));
	endtask
	task wrap_up;
		$display("Compared %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#500000;
		bad_count++;
		wrap_up;
	end
	// ======================================
	// Main sequence
	initial begin
		repeat (12) @(posedge CLK_SYS);
		ARST_N <= 1'b1;
		rd(`OFS_CLK_CTRL, 2'h0, v);
		chk(v, 32'(`CLK_CTRL_RST));
		rd(`OFS_CE_BASE, 2'h0, v);
		chk(v, 32'(`CE_RST));
		rd(8'h30, 2'h2, v);
		chk(v, 32'h0);
		wr(8'h30, 32'h1, 2'h2);
		$display("Test registers done");
		for (int i = 0; i < 6; i++) begin
			wr(`OFS_CLK_CTRL, {28'h0, 2'(i % 3), 2'(1 + i / 3)}, 2'h0);
			repeat (30) @(posedge CLK_SYS);
			pw(0, 2 + i / 3);
			pw(1, (2 + i / 3) << (i % 3));
		end
		wr(`OFS_CLK_CTRL, 32'h4, 2'h0);
		repeat (30) @(posedge CLK_SYS);
		pw(0, 5);
		pw(1, 10);
		wr(`OFS_CLK_CTRL, 32'h1, 2'h0);
		$display("Test clocks done");
		wr(`OFS_WDATA_LO, 32'h89AB_CDEF, 2'h0);
		wr(`OFS_WDATA_HI, 32'h0123_4567, 2'h0);
		acc(1, 2'h1, ce_cfg_type'{3'h3, 6'h2, 4'h1, 3'h1, 6'h3, 4'h2}, 0, 0, 2);
		acc(0, 2'h1, ce_cfg_type'{3'h3, 6'h2, 4'h1, 3'h1, 6'h3, 4'h2}, 0, 0, 3);
		rd(`OFS_RDATA_LO, 2'h0, v);
		chk(v, 32'h89AB_CDEF);
		rd(`OFS_RDATA_HI, 2'h0, v);
		chk(v, 32'h0123_4567);
		acc(0, 2'h2, ce_cfg_type'{3'h1, 6'h1, 4'h1, 3'h2, 6'h3, 4'h1}, 1, 7, 9);
		acc(0, 2'h3, ce_cfg_type'{3'h1, 6'h1, 4'h1, 3'h1, 6'h6, 4'h3}, 1, 3, 6);
		acc(1, 2'h0, ce_cfg_type'{3'h1, 6'h3, 4'h2, 3'h1, 6'h1, 4'h1}, 1, 5, 7);
		$display("Test accesses done");
		wrap_up;
	end
endmodule // test_async_memory_strobe_clocking
